// File: hdl/odcr_output_driver_ctrl.sv
// Overview of operation
// - Left headphone gain field D6-D3 selects 0 to 9 dB in 1 dB steps.
// - Right headphone gain field D6-D3 selects 0 to 9 dB in 1 dB steps.
// - Left headphone D2: zero mutes, one unmutes; resets muted.
// - Right headphone D2: zero mutes, one unmutes; resets muted.
// - Left headphone D1 picks power-down state: common mode or high impedance; resets one.
// - Right headphone D1 picks power-down state: common mode or high impedance; resets one.
// - Left headphone D0 reads one only once every programmed gain is applied.
// - Right headphone D0 reads one only once every programmed gain is applied.
// - Speaker gain field D4-D3 selects 6, 12, 18 or 24 dB.
// - Speaker D2 zero keeps driver muted, as after reset; one unmutes.
// - Speaker D0 reads one once all programmed speaker gains are applied.
// - Control D7-D5 set debounce, 0 to 512 us, doubling, from 1 MHz.
// - Oscillator source gives 0 to 500 us, scaling with oscillator rate.
// - Debounce clock period is one eighth of the debounce time.
// - Control D4-D3 select DAC performance mode; 10 is reserved.
`timescale 1ns/1ns
`default_nettype none

module odcr_output_driver_ctrl (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port from the control interface, page already selected
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  output logic [7:0] reg_rd_data,
  // Short-circuit detection and its timing sources
  input wire logic sc_raw,
  input wire logic osc_clk_in,
  input wire logic osc_src_sel,
  output logic short_circuit_detected,
  // Driver controls
  output logic [3:0] left_headphone_driver_gain,
  output logic left_headphone_driver_unmute,
  output logic left_headphone_driver_hiz_pd,
  output logic [3:0] right_headphone_driver_gain,
  output logic right_headphone_driver_unmute,
  output logic right_headphone_driver_hiz_pd,
  output logic [1:0] mono_speaker_driver_gain,
  output logic mono_speaker_driver_unmute,
  output logic [1:0] dac_perf_mode,
  output logic [1:0] hp_power_ctrl
);

  typedef struct packed {
    logic [3:0] lhp_tgt;
    logic [3:0] lhp_act;
    logic lhp_unmute;
    logic lhp_hiz;
    logic [3:0] rhp_tgt;
    logic [3:0] rhp_act;
    logic rhp_unmute;
    logic rhp_hiz;
    logic [1:0] mono_tgt;
    logic [1:0] mono_act;
    logic mono_unmute;
    logic [2:0] deb_code;
    logic [1:0] perf;
    logic [1:0] hp_pwr;
    logic [6:0] step_cnt;
    logic [6:0] us_cnt;
    logic [9:0] tick_cnt;
    logic [2:0] deb_cnt;
    logic sc_s1;
    logic sc_s2;
    logic sc_s3;
    logic sc_stable;
    logic sc_out;
    logic osc_s1;
    logic osc_s2;
    logic osc_s3;
    logic osc_stable;
    logic sel_s1;
    logic sel_s2;
    logic sel_s3;
    logic sel_src;
    logic [7:0] rd_data;
  } odcr_state_type;

  odcr_state_type state_ff;
  odcr_state_type nxt_state;

  function automatic logic [3:0] odcr_step4(input logic [3:0] act, input logic [3:0] tgt);
    if (act < tgt) begin
      return act + 4'h1;
    end else if (act > tgt) begin
      return act - 4'h1;
    end
    return act;
  endfunction : odcr_step4

  function automatic logic [1:0] odcr_step2(input logic [1:0] act, input logic [1:0] tgt);
    if (act < tgt) begin
      return act + 2'h1;
    end else if (act > tgt) begin
      return act - 2'h1;
    end
    return act;
  endfunction : odcr_step2

  localparam logic [9:0] OSC_EDGES_PER_UNIT_W = 10'(odcr_pkg::OSC_EDGES_PER_UNIT);

  // Units of 1 us (or 8 oscillator edges) per debounce tick, for codes 1..7
  function automatic logic [9:0] odcr_tick_limit(input logic [2:0] code, input logic osc);
    logic [9:0] units;
    units = 10'h001 << (code - 3'h1);
    if (osc) begin
      return 10'(units * 10'(OSC_EDGES_PER_UNIT_W));
    end
    return units;
  endfunction : odcr_tick_limit

  function automatic logic [7:0] odcr_read(input logic [7:0] addr, input odcr_state_type s);
    logic [7:0] d;
    d = 8'h00;
    case (addr)
      odcr_pkg::LHP_CTRL_OFS: begin
        d[odcr_pkg::HP_GAIN_MSB:odcr_pkg::HP_GAIN_LSB] = s.lhp_tgt;
        d[odcr_pkg::UNMUTE_BIT] = s.lhp_unmute;
        d[odcr_pkg::HIZ_PD_BIT] = s.lhp_hiz;
        d[odcr_pkg::APPLIED_BIT] = (s.lhp_act == s.lhp_tgt);
      end
      odcr_pkg::RHP_CTRL_OFS: begin
        d[odcr_pkg::HP_GAIN_MSB:odcr_pkg::HP_GAIN_LSB] = s.rhp_tgt;
        d[odcr_pkg::UNMUTE_BIT] = s.rhp_unmute;
        d[odcr_pkg::HIZ_PD_BIT] = s.rhp_hiz;
        d[odcr_pkg::APPLIED_BIT] = (s.rhp_act == s.rhp_tgt);
      end
      odcr_pkg::MONO_CTRL_OFS: begin
        d[odcr_pkg::MONO_GAIN_MSB:odcr_pkg::MONO_GAIN_LSB] = s.mono_tgt;
        d[odcr_pkg::UNMUTE_BIT] = s.mono_unmute;
        d[odcr_pkg::APPLIED_BIT] = (s.mono_act == s.mono_tgt);
      end
      odcr_pkg::HP_COMMON_OFS: begin
        d[odcr_pkg::DEB_MSB:odcr_pkg::DEB_LSB] = s.deb_code;
        d[odcr_pkg::PERF_MSB:odcr_pkg::PERF_LSB] = s.perf;
        d[odcr_pkg::HP_PWR_MSB:odcr_pkg::HP_PWR_LSB] = s.hp_pwr;
      end
      default: begin
        d = 8'h00;
      end
    endcase
    return d;
  endfunction : odcr_read

  localparam logic [6:0] STEP_LAST = 7'(odcr_pkg::GAIN_STEP_CYCLES - 1);
  localparam logic [6:0] US_LAST = 7'(odcr_pkg::DEB_UNIT_CYCLES - 1);
  localparam logic [2:0] DEB_LAST = 3'(odcr_pkg::DEB_TICKS - 1);

  logic unit_pulse;
  logic deb_tick;
  logic [3:0] wr_hp_gain;

  always_comb begin
    nxt_state = state_ff;
    // Reserved codes saturate at 9 dB so the driver never sees an undefined gain
    wr_hp_gain = reg_wr_data[odcr_pkg::HP_GAIN_MSB:odcr_pkg::HP_GAIN_LSB];
    if (wr_hp_gain > odcr_pkg::HP_GAIN_MAX) begin
      wr_hp_gain = odcr_pkg::HP_GAIN_MAX;
    end

    // Register writes; status bit D0 is not stored anywhere
    if (reg_wr_en) begin
      case (reg_addr)
        odcr_pkg::LHP_CTRL_OFS: begin
          nxt_state.lhp_tgt = wr_hp_gain;
          nxt_state.lhp_unmute = reg_wr_data[odcr_pkg::UNMUTE_BIT];
          nxt_state.lhp_hiz = reg_wr_data[odcr_pkg::HIZ_PD_BIT];
        end
        odcr_pkg::RHP_CTRL_OFS: begin
          nxt_state.rhp_tgt = wr_hp_gain;
          nxt_state.rhp_unmute = reg_wr_data[odcr_pkg::UNMUTE_BIT];
          nxt_state.rhp_hiz = reg_wr_data[odcr_pkg::HIZ_PD_BIT];
        end
        odcr_pkg::MONO_CTRL_OFS: begin
          nxt_state.mono_tgt = reg_wr_data[odcr_pkg::MONO_GAIN_MSB:odcr_pkg::MONO_GAIN_LSB];
          nxt_state.mono_unmute = reg_wr_data[odcr_pkg::UNMUTE_BIT];
        end
        odcr_pkg::HP_COMMON_OFS: begin
          nxt_state.deb_code = reg_wr_data[odcr_pkg::DEB_MSB:odcr_pkg::DEB_LSB];
          nxt_state.perf = reg_wr_data[odcr_pkg::PERF_MSB:odcr_pkg::PERF_LSB];
          nxt_state.hp_pwr = reg_wr_data[odcr_pkg::HP_PWR_MSB:odcr_pkg::HP_PWR_LSB];
        end
        default: begin
          nxt_state.hp_pwr = state_ff.hp_pwr;
        end
      endcase
    end

    // Gains ramp one step per interval to avoid pops; the flag tracks arrival
    if (state_ff.step_cnt == STEP_LAST) begin
      nxt_state.step_cnt = 7'h00;
      nxt_state.lhp_act = odcr_step4(state_ff.lhp_act, state_ff.lhp_tgt);
      nxt_state.rhp_act = odcr_step4(state_ff.rhp_act, state_ff.rhp_tgt);
      nxt_state.mono_act = odcr_step2(state_ff.mono_act, state_ff.mono_tgt);
    end else begin
      nxt_state.step_cnt = state_ff.step_cnt + 7'h01;
    end

    // Pin synchronisers; a level counts once stages two and three agree
    nxt_state.sc_s1 = sc_raw;
    nxt_state.sc_s2 = state_ff.sc_s1;
    nxt_state.sc_s3 = state_ff.sc_s2;
    if (state_ff.sc_s2 == state_ff.sc_s3) begin
      nxt_state.sc_stable = state_ff.sc_s3;
    end
    nxt_state.osc_s1 = osc_clk_in;
    nxt_state.osc_s2 = state_ff.osc_s1;
    nxt_state.osc_s3 = state_ff.osc_s2;
    if (state_ff.osc_s2 == state_ff.osc_s3) begin
      nxt_state.osc_stable = state_ff.osc_s3;
    end
    // Source select is a pin as well, so it may change at any time
    nxt_state.sel_s1 = osc_src_sel;
    nxt_state.sel_s2 = state_ff.sel_s1;
    nxt_state.sel_s3 = state_ff.sel_s2;
    if (state_ff.sel_s2 == state_ff.sel_s3) begin
      nxt_state.sel_src = state_ff.sel_s3;
    end

    // Base unit: 1 us from the system clock, or one oscillator edge
    unit_pulse = 1'b0;
    if (state_ff.us_cnt == US_LAST) begin
      nxt_state.us_cnt = 7'h00;
      unit_pulse = !state_ff.sel_src;
    end else begin
      nxt_state.us_cnt = state_ff.us_cnt + 7'h01;
    end
    if (state_ff.sel_src && (state_ff.osc_s2 == state_ff.osc_s3)
        && state_ff.osc_s3 && !state_ff.osc_stable) begin
      unit_pulse = 1'b1;
    end

    // Debounce tick is one eighth of the selected time
    deb_tick = 1'b0;
    if (unit_pulse) begin
      if (state_ff.tick_cnt
          >= odcr_tick_limit(state_ff.deb_code, state_ff.sel_src) - 10'h001) begin
        nxt_state.tick_cnt = 10'h000;
        deb_tick = 1'b1;
      end else begin
        nxt_state.tick_cnt = state_ff.tick_cnt + 10'h001;
      end
    end

    // Any bounce back restarts the count of eight ticks
    if (state_ff.deb_code == odcr_pkg::DEB_RST) begin
      nxt_state.sc_out = state_ff.sc_stable;
      nxt_state.deb_cnt = 3'h0;
    end else if (state_ff.sc_stable == state_ff.sc_out) begin
      nxt_state.deb_cnt = 3'h0;
    end else if (deb_tick) begin
      if (state_ff.deb_cnt == DEB_LAST) begin
        nxt_state.sc_out = state_ff.sc_stable;
        nxt_state.deb_cnt = 3'h0;
      end else begin
        nxt_state.deb_cnt = state_ff.deb_cnt + 3'h1;
      end
    end

    nxt_state.rd_data = odcr_read(reg_addr, state_ff);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff <= '{
        lhp_tgt: odcr_pkg::HP_GAIN_RST, lhp_act: odcr_pkg::HP_GAIN_RST,
        lhp_unmute: odcr_pkg::UNMUTE_RST, lhp_hiz: odcr_pkg::HIZ_PD_RST,
        rhp_tgt: odcr_pkg::HP_GAIN_RST, rhp_act: odcr_pkg::HP_GAIN_RST,
        rhp_unmute: odcr_pkg::UNMUTE_RST, rhp_hiz: odcr_pkg::HIZ_PD_RST,
        mono_tgt: odcr_pkg::MONO_GAIN_RST, mono_act: odcr_pkg::MONO_GAIN_RST,
        mono_unmute: odcr_pkg::UNMUTE_RST, deb_code: odcr_pkg::DEB_RST,
        perf: odcr_pkg::PERF_RST, hp_pwr: odcr_pkg::HP_PWR_RST,
        default: '0
      };
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign reg_rd_data = state_ff.rd_data;
  assign short_circuit_detected = state_ff.sc_out;
  assign left_headphone_driver_gain = state_ff.lhp_act;
  assign left_headphone_driver_unmute = state_ff.lhp_unmute;
  assign left_headphone_driver_hiz_pd = state_ff.lhp_hiz;
  assign right_headphone_driver_gain = state_ff.rhp_act;
  assign right_headphone_driver_unmute = state_ff.rhp_unmute;
  assign right_headphone_driver_hiz_pd = state_ff.rhp_hiz;
  assign mono_speaker_driver_gain = state_ff.mono_act;
  assign mono_speaker_driver_unmute = state_ff.mono_unmute;
  assign dac_perf_mode = state_ff.perf;
  assign hp_power_ctrl = state_ff.hp_pwr;

  default clocking odcr_cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  left_gain_range_a: assert property (state_ff.lhp_act <= 4'h9)
    else $error("left headphone gain above 9 dB");
  right_gain_range_a: assert property (state_ff.rhp_act <= 4'h9)
    else $error("right headphone gain above 9 dB");
  left_mute_write_a: assert property (reg_wr_en && reg_addr == 8'h28
    |=> left_headphone_driver_unmute == $past(reg_wr_data[2]))
    else $error("left mute bit not applied");
  right_mute_write_a: assert property (reg_wr_en && reg_addr == 8'h29
    |=> right_headphone_driver_unmute == $past(reg_wr_data[2]))
    else $error("right mute bit not applied");
  left_hiz_write_a: assert property (reg_wr_en && reg_addr == 8'h28
    |=> left_headphone_driver_hiz_pd == $past(reg_wr_data[1]))
    else $error("left power-down state not applied");
  right_hiz_hold_a: assert property (!(reg_wr_en && reg_addr == 8'h29)
    |=> $stable(right_headphone_driver_hiz_pd))
    else $error("right power-down state changed without write");
  left_applied_flag_a: assert property (reg_addr == 8'h28 && !reg_wr_en
    ##1 reg_addr == 8'h28 |=> reg_rd_data[0] == ($past(state_ff.lhp_act) == $past(state_ff.lhp_tgt)))
    else $error("left applied flag wrong");
  right_flag_drops_a: assert property (reg_wr_en && reg_addr == 8'h29
    && state_ff.step_cnt != STEP_LAST && reg_wr_data[6:3] != state_ff.rhp_act
    |=> state_ff.rhp_act != state_ff.rhp_tgt)
    else $error("right applied flag not pending after new gain");
  mono_ramp_step_a: assert property ($changed(mono_speaker_driver_gain)
    |-> $past(state_ff.step_cnt) == STEP_LAST)
    else $error("speaker gain moved off the step interval");
  mono_mute_write_a: assert property (reg_wr_en && reg_addr == 8'h2A
    |=> mono_speaker_driver_unmute == $past(reg_wr_data[2]))
    else $error("speaker mute bit not applied");
  mono_applied_a: assert property (state_ff.mono_act == state_ff.mono_tgt
    && !reg_wr_en |=> state_ff.mono_act == state_ff.mono_tgt)
    else $error("speaker gain left its target");
  debounce_eight_a: assert property ($changed(state_ff.sc_out) && $past(state_ff.deb_code) != 3'h0
    |-> $past(state_ff.deb_cnt) == 3'h7)
    else $error("debounce ended without eight ticks");
  perf_mode_write_a: assert property (reg_wr_en && reg_addr == 8'h2C
    |=> dac_perf_mode == $past(reg_wr_data[4:3]))
    else $error("performance mode not applied");

  left_ramp_done_c: cover property (state_ff.lhp_act != state_ff.lhp_tgt
    ##[1:1000] state_ff.lhp_act == state_ff.lhp_tgt);
  short_detect_c: cover property (state_ff.deb_code == 3'h1 && $rose(state_ff.sc_out));
  osc_source_c: cover property (state_ff.sel_src && deb_tick);

endmodule : odcr_output_driver_ctrl

`default_nettype wire

// File: hdl/odcr_pkg.sv
package odcr_pkg;

  // Register indices within the output-driver page
  localparam logic [7:0] LHP_CTRL_OFS = 8'h28;
  localparam logic [7:0] RHP_CTRL_OFS = 8'h29;
  localparam logic [7:0] MONO_CTRL_OFS = 8'h2A;
  localparam logic [7:0] RSVD_A_OFS = 8'h2B;
  localparam logic [7:0] HP_COMMON_OFS = 8'h2C;
  localparam logic [7:0] RSVD_B_OFS = 8'h2D;

  // Field positions
  localparam int HP_GAIN_LSB = 3;
  localparam int HP_GAIN_MSB = 6;
  localparam int MONO_GAIN_LSB = 3;
  localparam int MONO_GAIN_MSB = 4;
  localparam int UNMUTE_BIT = 2;
  localparam int HIZ_PD_BIT = 1;
  localparam int APPLIED_BIT = 0;
  localparam int DEB_LSB = 5;
  localparam int DEB_MSB = 7;
  localparam int PERF_LSB = 3;
  localparam int PERF_MSB = 4;
  localparam int HP_PWR_LSB = 1;
  localparam int HP_PWR_MSB = 2;

  // Values after reset, and the headphone gain limit
  localparam logic [3:0] HP_GAIN_RST = 4'h0;
  localparam logic [3:0] HP_GAIN_MAX = 4'h9;
  localparam logic [1:0] MONO_GAIN_RST = 2'h0;
  localparam logic UNMUTE_RST = 1'b0;
  localparam logic HIZ_PD_RST = 1'b1;
  localparam logic [2:0] DEB_RST = 3'h0;
  localparam logic [1:0] PERF_RST = 2'h0;
  localparam logic [1:0] HP_PWR_RST = 2'h0;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int GAIN_STEP_NS = 1000;
  localparam int GAIN_STEP_CYCLES = (GAIN_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEB_UNIT_NS = 1000;
  localparam int DEB_UNIT_CYCLES = (DEB_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEB_TICKS = 8;
  localparam int OSC_EDGES_PER_UNIT = 8;

endpackage : odcr_pkg

// File: verification/odcr_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module odcr_host_model (
  // Clock
  input wire logic sys_clk,
  // Register port
  output logic [7:0] reg_addr,
  output logic reg_wr_en,
  output logic [7:0] reg_wr_data,
  input wire logic [7:0] reg_rd_data
);
  initial begin
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wr_data = 8'h00;
  end

  // Gain codes stay within 0..9 in every caller value; only the first left write and the 8'hFF write to reserved register 2B set bit 0
  // Clearing a power-down state bit also means clearing bit 0 of register 33 elsewhere
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    if (addr != 8'h2D) begin
      @(negedge sys_clk);
      reg_addr <= addr;
      reg_wr_data <= data;
      reg_wr_en <= 1'b1;
      @(negedge sys_clk);
      reg_wr_en <= 1'b0;
      // Released data must not look valid
      reg_wr_data <= ~data;
    end
  endtask : write_reg

  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(negedge sys_clk);
    reg_addr <= addr;
    @(negedge sys_clk);
    data = reg_rd_data;
  endtask : read_reg
endmodule : odcr_host_model

`default_nettype wire

// File: verification/output_driver_control_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none

module output_driver_control_regs_tb;
  logic sys_clk;
  logic rst;
  logic sc_raw;
  logic osc_clk_in;
  logic osc_src_sel;
  logic [7:0] reg_addr;
  logic reg_wr_en;
  logic [7:0] reg_wr_data;
  logic [7:0] reg_rd_data;
  logic short_circuit_detected;
  logic [3:0] lg;
  logic lu;
  logic lz;
  logic [3:0] rg;
  logic ru;
  logic rz;
  logic [1:0] mg;
  logic mu;
  logic [1:0] perf;
  logic [1:0] pwr;
  logic [7:0] rd;
  logic [7:0] ctl [3];
  int n_fail;
  int n_compared;

  odcr_output_driver_ctrl i_dut (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .sc_raw(sc_raw),
    .osc_clk_in(osc_clk_in), .osc_src_sel(osc_src_sel),
    .short_circuit_detected(short_circuit_detected),
    .left_headphone_driver_gain(lg), .left_headphone_driver_unmute(lu),
    .left_headphone_driver_hiz_pd(lz), .right_headphone_driver_gain(rg),
    .right_headphone_driver_unmute(ru), .right_headphone_driver_hiz_pd(rz),
    .mono_speaker_driver_gain(mg), .mono_speaker_driver_unmute(mu),
    .dac_perf_mode(perf), .hp_power_ctrl(pwr)
  );

  odcr_host_model i_host (
    .sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Nominal oscillator, unrelated in phase to the system clock
  initial begin
    osc_clk_in = 1'b0;
    forever #61 osc_clk_in = ~osc_clk_in;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  task automatic rd_check(input logic [7:0] addr, input logic [7:0] mask, input logic [7:0] exp);
    logic [7:0] d;
    i_host.read_reg(addr, d);
    check(d & mask, exp, "readback");
  endtask : rd_check

  // Poll until every programmed gain is reported applied
  task automatic wait_applied(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    d = 8'h00;
    for (int i = 0; i < 1500 && d[0] !== 1'b1; i++) i_host.read_reg(addr, d);
    check(d, exp, "applied readback");
    if (d[0] !== 1'b1) give_verdict();
  endtask : wait_applied

  // Output must hold off for lo cycles, then settle within hi more
  task automatic wait_sc(input logic exp, input int lo, input int hi);
    repeat (lo) @(negedge sys_clk);
    check(short_circuit_detected, !exp, "early detect change");
    for (int i = 0; i < hi && short_circuit_detected !== exp; i++) @(negedge sys_clk);
    check(short_circuit_detected, exp, "detect level");
    if (short_circuit_detected !== exp) give_verdict();
  endtask : wait_sc

  initial begin
    n_fail = 0;
    n_compared = 0;
    rst = 1'b1;
    sc_raw = 1'b0;
    osc_src_sel = 1'b0;
    ctl = '{8'hFE, 8'h08, 8'h00};
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;

    rd_check(8'h28, 8'hFE, 8'h02);
    rd_check(8'h29, 8'hFE, 8'h02);
    rd_check(8'h2A, 8'hFE, 8'h00);
    rd_check(8'h2C, 8'hFF, 8'h00);
    check({lu, lz, ru, rz, mu}, 8'h0A, "reset outputs");
    $display("reset test done");

    // Bit 0 set in the write data must not stick
    i_host.write_reg(8'h28, 8'h2F);
    rd_check(8'h28, 8'hFF, 8'h2E);
    check(lu, 8'h01, "left unmute");
    wait_applied(8'h28, 8'h2F);
    check(lg, 8'h05, "left gain");
    i_host.write_reg(8'h28, 8'h04);
    wait_applied(8'h28, 8'h05);
    check({lg, lz}, 8'h00, "left gain and pd");
    $display("left test done");

    i_host.write_reg(8'h29, 8'h48);
    rd_check(8'h29, 8'h01, 8'h00);
    wait_applied(8'h29, 8'h49);
    check({rg, ru, rz}, 8'h24, "right outputs");
    $display("right test done");

    for (int c = 0; c < 4; c++) begin
      i_host.write_reg(8'h2A, {3'h0, 2'(c), 3'h4});
      wait_applied(8'h2A, {3'h0, 2'(c), 3'h5});
      check({mg, mu}, {5'h00, 2'(c), 1'b1}, "speaker outputs");
    end
    $display("speaker test done");

    for (int k = 0; k < 3; k++) begin
      i_host.write_reg(8'h2C, ctl[k]);
      rd_check(8'h2C, 8'hFF, ctl[k]);
      check({perf, pwr}, {4'h0, ctl[k][4:1]}, "perf and power");
    end
    $display("control test done");

    i_host.write_reg(8'h2B, 8'hFF);
    rd_check(8'h2B, 8'hFF, 8'h00);
    rd_check(8'h2D, 8'hFF, 8'h00);
    $display("reserved test done");

    sc_raw = 1'b1;
    wait_sc(1'b1, 0, 10);
    sc_raw = 1'b0;
    wait_sc(1'b0, 0, 10);
    i_host.write_reg(8'h2C, 8'h20);
    sc_raw = 1'b1;
    wait_sc(1'b1, 650, 400);
    sc_raw = 1'b0;
    wait_sc(1'b0, 650, 400);
    osc_src_sel = 1'b1;
    sc_raw = 1'b1;
    wait_sc(1'b1, 600, 400);
    $display("debounce test done");
    give_verdict();
  end
endmodule : output_driver_control_regs_tb

`default_nettype wire
